// ==== hdl/bbms_pkg.sv ====
// Constants, types and encodings for the buck-boost mode sequencer
// Behaviour
// - Regulator runs only while the enable input is high.
// - Enable low enters power-down; no active output discharge.
// - Bleed bit set with converter-on clear stops switching and connects bleed resistor.
// - After undervoltage clear and enable, initialise and load trim before soft-start.
// - Soft-start ramps the output target at the programmed rate to the setting.
// - Peak current limit enters hiccup, shutdown or current limiting per selection.
// - Hiccup holds shutdown for 100 ms, then restarts.
// - Over-temperature stops all switching.
// - After cooling by the margin, repeat soft-start then regulate at the setting.
// - With input near output, alternate buck and boost as regulation needs.
// - Buck PWM: output switch closed, boost low open, buck pair synchronous.
// - Boost PWM: buck high closed, buck low open, boost pair synchronous.
// - Buck PFM: output switch closed, boost low open, buck pair discontinuous.
// - Boost PFM pulse: high and boost low until threshold, then low and output.
// - PFM pulses repeat to upper threshold, then stop until lower threshold.
// - Serial clock and data inputs suppress pulses narrower than 50 ns.
// - Each fault sets its own flag bit; reading the flag register clears it.
package bbms_pkg;
    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned HICCUP_MS       = 100;
    localparam int unsigned HICCUP_CYCLES   = HICCUP_MS * 1000 * CLK_MHZ;
    localparam int unsigned GLITCH_NS       = 50;
    localparam int unsigned GLITCH_CYCLES   = (GLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DEADTIME_CYCLES = 2;
    localparam int unsigned INIT_CYCLES     = 16;
    localparam int unsigned TARGET_W        = 8;

    // Overload response selections
    localparam logic [1:0] OVL_HICCUP   = 2'h0;
    localparam logic [1:0] OVL_SHUTDOWN = 2'h1;
    localparam logic [1:0] OVL_LIMIT    = 2'h2;

    // Fault flag bit positions
    localparam int unsigned FLG_OC    = 0;
    localparam int unsigned FLG_OT    = 1;
    localparam int unsigned FLG_OVR   = 2;
    localparam int unsigned FLG_UNDER = 3;
    localparam int unsigned FLG_W     = 4;

    // Sequencer states, Gray coded along the start-up path
    typedef enum logic [3:0] {
        BBMS_OFF     = 4'h0,
        BBMS_INIT    = 4'h1,
        BBMS_TRIM    = 4'h3,
        BBMS_SOFT    = 4'h2,
        BBMS_RUN     = 4'h6,
        BBMS_HICCUP  = 4'h7,
        BBMS_LATCHED = 4'h5,
        BBMS_HOT     = 4'h4,
        BBMS_BLEED   = 4'hC
    } bbms_state_e;

    // Switch gate drive: a buck high, b buck low, c boost low, d boost output
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } bbms_gate_s;

    localparam bbms_gate_s GATES_OFF = '{a: 1'b0, b: 1'b0, c: 1'b0, d: 1'b0};

    // Analog comparator inputs
    typedef struct packed {
        logic uvlo_ok;
        logic peak_ilim;
        logic pfm_ipk;
        logic izero;
        logic vout_hi;
        logic vout_lo;
        logic pwm_on;
        logic vin_above;
    } bbms_comp_s;
endpackage : bbms_pkg

// ==== hdl/bbms_seq.sv ====
// Mode sequencer and gate control for the buck-boost converter
`timescale 1ns/1ns
module bbms_seq #(
    parameter int unsigned HICCUP_CYC = bbms_pkg::HICCUP_CYCLES,
    parameter int unsigned INIT_CYC   = bbms_pkg::INIT_CYCLES
) (
    input  wire logic                          sys_clk_in,
    input  wire logic                          reset_n_in,
    input  wire logic                          enable_in,
    input  wire bbms_pkg::bbms_comp_s          comp_in,
    input  wire logic                          overheat_limit_in,
    input  wire logic                          overheat_recovery_margin_in,
    input  wire logic                          conv_on_in,
    input  wire logic                          output_bleed_on_in,
    input  wire logic                          pfm_mode_in,
    input  wire logic [1:0]                    overload_response_select_in,
    input  wire logic [bbms_pkg::TARGET_W-1:0] target_in,
    input  wire logic [bbms_pkg::TARGET_W-1:0] ramp_step_in,
    input  wire logic                          trim_done_in,
    input  wire logic                          set_over_in,
    input  wire logic                          set_under_in,
    input  wire logic                          flag_read_in,
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output logic                               trim_load_out,
    output bbms_pkg::bbms_gate_s               gate_out,
    output logic                               bleed_out,
    output logic                               ilimit_out,
    output logic [bbms_pkg::TARGET_W-1:0]      ramp_target_out,
    output logic [bbms_pkg::FLG_W-1:0]         fault_flag_reg_out,
    output logic                               scl_clean_out,
    output logic                               sda_clean_out,
    output logic                               powered_out
);
    // Sequencer state, its next value, dwell counter and ramp value
    bbms_pkg::bbms_state_e         state_reg;
    bbms_pkg::bbms_state_e         state_next;
    logic [31:0]                   cnt_reg;
    logic [bbms_pkg::TARGET_W-1:0] tgt_reg;

    // Gate drive path
    bbms_pkg::bbms_gate_s          want;
    bbms_pkg::bbms_gate_s          gate_reg;
    logic [1:0]                    dead_reg;

    // Mode choice and PFM hysteresis
    logic                          boost_reg;
    logic                          pfm_act_reg;
    logic                          pfm_ph_reg;

    // Qualifiers: run is shared by several processes, oc_trip and ramp_done feed only the next state
    logic                          run;
    logic                          oc_trip;
    logic                          ramp_done;

    // Whole-block gating: enable low forces power-down
    assign run = enable_in && comp_in.uvlo_ok;

    // Every selection but current limiting leaves the switching states on a peak hit
    assign oc_trip = comp_in.peak_ilim &&
                     overload_response_select_in != bbms_pkg::OVL_LIMIT;

    // One more step reaches the setting; the extra bit keeps the carry
    assign ramp_done = ({1'b0, tgt_reg} + {1'b0, ramp_step_in}) >= {1'b0, target_in};

    // Glitch filter: a level must persist before it is accepted
    function automatic logic filt_next(input logic raw, input logic cur,
                                       input logic [2:0] c);
        filt_next = (c >= 3'(bbms_pkg::GLITCH_CYCLES)) ? raw : cur;
    endfunction : filt_next

    // Serial lines: index 0 clock, index 1 data
    logic [1:0]                    line_raw;
    logic [2:0]                    line_cnt_reg [2];
    logic                          line_clean_reg [2];

    assign line_raw = {sda_in, scl_in};

    // Serial line filters suppress short pulses, one per line
    for (genvar i = 0; i < 2; i++) begin : g_filt
        always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                line_cnt_reg[i]   <= 3'h0;
                line_clean_reg[i] <= 1'b1;
            end else begin
                line_cnt_reg[i]   <= (line_raw[i] == line_clean_reg[i]) ? 3'h0
                                     : line_cnt_reg[i] + 3'h1;
                line_clean_reg[i] <= filt_next(line_raw[i], line_clean_reg[i],
                                               line_cnt_reg[i]);
            end
        end
    end

    // Filtered lines leave straight from their flip-flops
    assign scl_clean_out = line_clean_reg[0];
    assign sda_clean_out = line_clean_reg[1];

    // Next state; enable low overrides every transition
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            bbms_pkg::BBMS_OFF: begin
                state_next = bbms_pkg::BBMS_INIT;
            end
            bbms_pkg::BBMS_INIT: begin
                if (cnt_reg >= INIT_CYC) begin
                    state_next = bbms_pkg::BBMS_TRIM;
                end
            end
            bbms_pkg::BBMS_TRIM: begin
                if (trim_done_in) begin
                    state_next = bbms_pkg::BBMS_SOFT;
                end
            end
            bbms_pkg::BBMS_SOFT, bbms_pkg::BBMS_RUN: begin
                if (overheat_limit_in) begin
                    state_next = bbms_pkg::BBMS_HOT;
                end else if (oc_trip) begin
                    state_next = (overload_response_select_in == bbms_pkg::OVL_HICCUP)
                                 ? bbms_pkg::BBMS_HICCUP : bbms_pkg::BBMS_LATCHED;
                end else if (output_bleed_on_in && !conv_on_in) begin
                    state_next = bbms_pkg::BBMS_BLEED;
                end else if (state_reg == bbms_pkg::BBMS_SOFT && ramp_done) begin
                    state_next = bbms_pkg::BBMS_RUN;
                end
            end
            bbms_pkg::BBMS_HICCUP: begin
                if (cnt_reg >= HICCUP_CYC - 1) begin
                    state_next = bbms_pkg::BBMS_INIT;
                end
            end
            bbms_pkg::BBMS_HOT: begin
                if (overheat_recovery_margin_in) begin
                    state_next = bbms_pkg::BBMS_SOFT;
                end
            end
            bbms_pkg::BBMS_BLEED: begin
                if (conv_on_in) begin
                    state_next = bbms_pkg::BBMS_SOFT;
                end
            end
            bbms_pkg::BBMS_LATCHED: begin
                state_next = bbms_pkg::BBMS_LATCHED; // Left only by enable low or uvlo_ok low
            end
            default: begin
                state_next = bbms_pkg::BBMS_OFF;
            end
        endcase
        if (!run) begin
            state_next = bbms_pkg::BBMS_OFF;
        end
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= bbms_pkg::BBMS_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Dwell counter: cleared on each state change, runs in timed states
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_reg <= 32'h0000_0000;
        end else if (state_next != state_reg) begin
            cnt_reg <= 32'h0000_0000;
        end else if (state_reg == bbms_pkg::BBMS_INIT ||
                     state_reg == bbms_pkg::BBMS_HICCUP) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
    end

    // Ramp value: climbs from zero in soft-start, follows the setting in run
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tgt_reg <= '0;
        end else if (!run) begin
            tgt_reg <= '0;
        end else if (state_next == bbms_pkg::BBMS_SOFT &&
                     state_reg != bbms_pkg::BBMS_SOFT) begin
            tgt_reg <= '0;
        end else if (state_reg == bbms_pkg::BBMS_SOFT &&
                     state_next == bbms_pkg::BBMS_RUN) begin
            tgt_reg <= target_in;
        end else if (state_reg == bbms_pkg::BBMS_SOFT &&
                     state_next == bbms_pkg::BBMS_SOFT) begin
            tgt_reg <= tgt_reg + ramp_step_in;
        end else if (state_reg == bbms_pkg::BBMS_RUN &&
                     state_next == bbms_pkg::BBMS_RUN) begin
            tgt_reg <= target_in;
        end
    end

    // Buck while the input stands above the output
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            boost_reg <= 1'b0;
        end else begin
            boost_reg <= !comp_in.vin_above;
        end
    end

    // PFM hysteresis: stop at the upper level, resume at the lower
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pfm_act_reg <= 1'b1;
        end else if (comp_in.vout_hi) begin
            pfm_act_reg <= 1'b0;
        end else if (comp_in.vout_lo) begin
            pfm_act_reg <= 1'b1;
        end
    end

    // PFM pulse phase: charge to the peak, then dump to zero current
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pfm_ph_reg <= 1'b0;
        end else if (!pfm_ph_reg && comp_in.pfm_ipk) begin
            pfm_ph_reg <= 1'b1;
        end else if (pfm_ph_reg && comp_in.izero) begin
            pfm_ph_reg <= 1'b0;
        end
    end

    // Wanted switch pattern for the present mode
    always_comb begin
        want = bbms_pkg::GATES_OFF;
        if (state_reg == bbms_pkg::BBMS_SOFT || state_reg == bbms_pkg::BBMS_RUN) begin
            if (comp_in.peak_ilim) begin
                want = bbms_pkg::GATES_OFF;
            end else if (!pfm_mode_in) begin
                if (!boost_reg) begin
                    want = '{a: comp_in.pwm_on, b: !comp_in.pwm_on,
                             c: 1'b0, d: 1'b1};
                end else begin
                    want = '{a: 1'b1, b: 1'b0, c: comp_in.pwm_on,
                             d: !comp_in.pwm_on};
                end
            end else if (pfm_act_reg || pfm_ph_reg) begin
                if (!boost_reg) begin
                    want = '{a: !pfm_ph_reg, b: pfm_ph_reg,
                             c: 1'b0, d: 1'b1};
                end else begin
                    want = '{a: !pfm_ph_reg, b: pfm_ph_reg,
                             c: !pfm_ph_reg, d: pfm_ph_reg};
                end
            end
        end
    end

    // Some closed switch is no longer wanted
    logic                          opening;
    assign opening = (gate_reg & ~want) != bbms_pkg::GATES_OFF;

    // Break-before-make gate update
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gate_reg <= bbms_pkg::GATES_OFF;
        end else if (opening) begin
            gate_reg <= gate_reg & want;
        end else if (dead_reg >= 2'(bbms_pkg::DEADTIME_CYCLES)) begin
            gate_reg <= want;
        end
    end

    // Dead time counter, restarted by every opening step
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dead_reg <= 2'h0;
        end else if (opening) begin
            dead_reg <= 2'h0;
        end else if (dead_reg < 2'(bbms_pkg::DEADTIME_CYCLES)) begin
            dead_reg <= dead_reg + 2'h1;
        end
    end

    // Fault events, one bit per flag position
    logic [bbms_pkg::FLG_W-1:0]    flag_set;
    assign flag_set[bbms_pkg::FLG_OC]    = comp_in.peak_ilim && run;
    assign flag_set[bbms_pkg::FLG_OT]    = overheat_limit_in && run;
    assign flag_set[bbms_pkg::FLG_OVR]   = set_over_in;
    assign flag_set[bbms_pkg::FLG_UNDER] = set_under_in;

    // Fault flags: set wins over read clear
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fault_flag_reg_out <= '0;
        end else begin
            fault_flag_reg_out <= (flag_read_in ? '0 : fault_flag_reg_out) | flag_set;
        end
    end

    // Bleed resistor follows the bleed state
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bleed_out <= 1'b0;
        end else begin
            bleed_out <= (state_reg == bbms_pkg::BBMS_BLEED);
        end
    end

    // Current limiting flag
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ilimit_out <= 1'b0;
        end else begin
            ilimit_out <= comp_in.peak_ilim &&
                          overload_response_select_in == bbms_pkg::OVL_LIMIT;
        end
    end

    // Ramp value to the error amplifier
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ramp_target_out <= '0;
        end else begin
            ramp_target_out <= tgt_reg;
        end
    end

    // Trim load request
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            trim_load_out <= 1'b0;
        end else begin
            trim_load_out <= (state_reg == bbms_pkg::BBMS_TRIM);
        end
    end

    // Powered status
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            powered_out <= 1'b0;
        end else begin
            powered_out <= run;
        end
    end

    assign gate_out = gate_reg;
endmodule : bbms_seq

// ==== verification/bbms_seq_props.sv ====
// Concurrent checks on the mode sequencer ports
`timescale 1ns/1ns
module bbms_seq_props #(
    parameter int unsigned HICCUP_CYC = 50,
    parameter int unsigned INIT_CYC   = 16
) (
    input wire logic                 sys_clk_in,
    input wire logic                 reset_n_in,
    input wire logic                 enable_in,
    input wire bbms_pkg::bbms_comp_s comp_in,
    input wire logic                 overheat_limit_in,
    input wire logic [1:0]           overload_response_select_in,
    input wire logic [7:0]           target_in,
    input wire logic [7:0]           ramp_step_in,
    input wire logic                 scl_in,
    input wire logic                 trim_load_out,
    input wire bbms_pkg::bbms_gate_s gate_out,
    input wire logic                 bleed_out,
    input wire logic [7:0]           ramp_target_out,
    input wire logic [3:0]           fault_flag_reg_out,
    input wire logic                 powered_out,
    input wire logic                 scl_clean_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    // Overcurrent hit while switching, then a quiet stretch of the stage
    sequence oc_hit;
        comp_in.peak_ilim && overload_response_select_in == bbms_pkg::OVL_HICCUP
            && gate_out != bbms_pkg::GATES_OFF;
    endsequence
    sequence held_off;
        (gate_out == bbms_pkg::GATES_OFF)[*8];
    endsequence
    a_off_when_low: assert property (
        (!enable_in)[*3] |-> gate_out == bbms_pkg::GATES_OFF && !bleed_out) else $error("live stage");
    a_no_shoot_through: assert property (
        !(gate_out.a && gate_out.b) && !(gate_out.c && gate_out.d)) else $error("shoot through");
    a_boost_needs_high: assert property (
        gate_out.c |-> gate_out.a) else $error("boost low without buck high");
    a_buck_low_output: assert property (
        gate_out.b |-> gate_out.d) else $error("buck low without output switch");
    a_trim_after_init: assert property (
        $rose(trim_load_out) |-> $past(powered_out, INIT_CYC + 1)) else $error("trim too early");
    a_ramp_step_size: assert property (
        ramp_target_out > $past(ramp_target_out) |-> ramp_target_out == target_in
            || ramp_target_out == 8'($past(ramp_target_out) + ramp_step_in)) else $error("bad ramp");
    a_hiccup_holds_off: assert property (
        oc_hit |-> ##[1:4] held_off) else $error("hiccup not off");
    a_overheat_stops: assert property (
        overheat_limit_in[*3] |-> gate_out == bbms_pkg::GATES_OFF) else $error("hot switching");
    a_bleed_no_switch: assert property (
        bleed_out && $past(bleed_out) |-> gate_out == bbms_pkg::GATES_OFF) else $error("bleed live");
    a_hot_flag_set: assert property (
        $rose(overheat_limit_in) |-> ##[1:2] fault_flag_reg_out[1]) else $error("no hot flag");
    a_glitch_filter: assert property (
        $fell(scl_clean_out) |-> !$past(scl_in) && !$past(scl_in, 5)) else $error("glitch passed");
endmodule : bbms_seq_props

bind bbms_seq bbms_seq_props #(.HICCUP_CYC(HICCUP_CYC), .INIT_CYC(INIT_CYC)) u_props (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .enable_in(enable_in),
    .comp_in(comp_in), .overheat_limit_in(overheat_limit_in),
    .overload_response_select_in(overload_response_select_in), .target_in(target_in),
    .ramp_step_in(ramp_step_in), .scl_in(scl_in), .trim_load_out(trim_load_out),
    .gate_out(gate_out), .bleed_out(bleed_out), .ramp_target_out(ramp_target_out),
    .fault_flag_reg_out(fault_flag_reg_out), .powered_out(powered_out),
    .scl_clean_out(scl_clean_out));

// ==== verification/bbms_stage_model.sv ====
// Behavioural power stage: inductor current and output level as counters
`timescale 1ns/1ns
module bbms_stage_model (
    input  wire logic                 sys_clk_in,
    input  wire logic                 reset_n_in,
    input  wire bbms_pkg::bbms_gate_s gate_in,
    output logic                      ipk_out,
    output logic                      izero_out,
    output logic                      vhi_out,
    output logic                      vlo_out,
    output logic [7:0]                pulses_out
);
    logic [3:0] cur_reg;
    logic [3:0] vout_reg;
    logic [3:0] decay_reg;
    // Charge through the high switch, dump into the output, load drains slowly
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cur_reg    <= 4'h0;
            vout_reg   <= 4'h0;
            decay_reg  <= 4'h0;
            pulses_out <= 8'h00;
        end else begin
            decay_reg <= decay_reg + 4'h1;
            if (gate_in.a && !gate_in.b && cur_reg != 4'hF) begin
                cur_reg <= cur_reg + 4'h1;
                if (cur_reg == 4'h3)
                    pulses_out <= pulses_out + 8'h01;
            end else if (!gate_in.a && cur_reg != 4'h0) begin
                cur_reg <= cur_reg - 4'h1;
                if (vout_reg != 4'hF)
                    vout_reg <= vout_reg + 4'h1;
            end else if (decay_reg == 4'h0 && vout_reg != 4'h0)
                vout_reg <= vout_reg - 4'h1;
        end
    end
    assign ipk_out   = cur_reg >= 4'h4;
    assign izero_out = cur_reg == 4'h0;
    assign vhi_out   = vout_reg >= 4'hC;
    assign vlo_out   = vout_reg <= 4'h4;
endmodule : bbms_stage_model

// ==== verification/tb.sv ====
// Self-checking bench for the buck-boost mode sequencer
`timescale 1ns/1ns
module tb;
    typedef struct {logic [1:0] sel; logic lim; logic rst;} bbms_row_s;
    bbms_row_s rows [3] = '{'{2'h0, 1'b0, 1'b1}, '{2'h1, 1'b0, 1'b0}, '{2'h2, 1'b1, 1'b0}};
    logic sys_clk_in = 1'b0, reset_n_in = 1'b0, en = 1'b0, uvlo = 1'b1, pk = 1'b0, hot = 1'b0;
    logic cool = 1'b0, conv = 1'b1, bleed = 1'b0, pfm = 1'b0, vin_hi = 1'b1, done = 1'b0;
    logic s_ov = 1'b0, s_un = 1'b0, rd = 1'b0, scl = 1'b1, ipk, izero, vhi, vlo, trim_load;
    logic bleed_o, ilim, powered, scl_c, sda_c;
    logic [1:0] sel = 2'h0;
    logic [7:0] tgt = 8'h40, ramp, pulses;
    logic [3:0] flags;
    bbms_pkg::bbms_gate_s gate;
    bbms_pkg::bbms_comp_s comp;
    int bad_count = 0, n_checks = 0, cyc = 0, k;
    wire is_off = (gate == bbms_pkg::GATES_OFF);
    assign comp = '{uvlo, pk, ipk, izero, vhi, vlo, cyc[2], vin_hi};
    always #5 sys_clk_in = ~sys_clk_in;
    bbms_seq #(.HICCUP_CYC(50)) u_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .enable_in(en), .comp_in(comp), .overheat_limit_in(hot), .conv_on_in(conv),
        .overheat_recovery_margin_in(cool), .output_bleed_on_in(bleed), .pfm_mode_in(pfm),
        .overload_response_select_in(sel), .target_in(tgt), .ramp_step_in(8'h08),
        .trim_done_in(done), .set_over_in(s_ov), .set_under_in(s_un), .flag_read_in(rd),
        .scl_in(scl), .sda_in(scl), .trim_load_out(trim_load), .gate_out(gate),
        .bleed_out(bleed_o), .ilimit_out(ilim), .ramp_target_out(ramp),
        .fault_flag_reg_out(flags), .scl_clean_out(scl_c), .sda_clean_out(sda_c),
        .powered_out(powered));
    bbms_stage_model u_stage (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .gate_in(gate),
        .ipk_out(ipk), .izero_out(izero), .vhi_out(vhi), .vlo_out(vlo), .pulses_out(pulses));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : tick
    // Enable, wait out init and trim load, ride the ramp to target
    task automatic power_up();
        done = 1'b0;
        en = 1'b1;
        for (k = 0; k < 60 && trim_load !== 1'b1; k++) tick(1);
        check(k >= 18, 8'h01);
        done = 1'b1;
        for (k = 0; k < 60 && ramp !== tgt; k++) tick(1);
        check(ramp, tgt);
        check(powered, 8'h01);
    endtask : power_up
    // Cycle ceiling against hangs
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        tick(10);
        reset_n_in = 1'b1;
        // Overload response rows
        foreach (rows[i]) begin
            sel = rows[i].sel;
            power_up();
            pk = 1'b1;
            tick(4);
            check(ilim, rows[i].lim);
            check(flags[0], 8'h01);
            if (!rows[i].lim) check(is_off, 8'h01);
            pk = 1'b0;
            for (k = 0; k < 150 && trim_load !== 1'b1; k++) tick(1);
            check(trim_load, rows[i].rst);
            if (rows[i].rst) check(k >= 50, 8'h01);
            en = 1'b0;
            rd = 1'b1;
            tick(1);
            rd = 1'b0;
            tick(3);
            check(is_off, 8'h01);
            check(powered, 8'h00);
        end
        // Thermal stop with range events, one read clears, then restart
        sel = 2'h0;
        power_up();
        {s_ov, s_un, hot} = 3'b111;
        tick(1);
        {s_ov, s_un} = 2'b00;
        tick(3);
        check(is_off, 8'h01);
        check(flags, 8'h0E);
        {hot, cool} = 2'b01;
        tick(2);
        check(ramp < tgt, 8'h01);
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        check(flags, 8'h00);
        for (k = 0; k < 60 && ramp !== tgt; k++) tick(1);
        check(ramp, tgt);
        // Bleed while enabled, then enable drops during bleed
        {conv, bleed} = 2'b01;
        tick(4);
        check({bleed_o, is_off}, 8'h03);
        en = 1'b0;
        tick(4);
        check({bleed_o, is_off}, 8'h01);
        {conv, bleed, pfm, vin_hi} = 4'b1010;
        // Boost PFM pulses, then buck PFM, buck PWM and boost PWM
        power_up();
        tick(300);
        check(pulses != 8'h00, 8'h01);
        vin_hi = 1'b1;
        tick(60);
        check(gate.c, 8'h00);
        pfm = 1'b0;
        tick(60);
        check(gate.c, 8'h00);
        vin_hi = 1'b0;
        tick(60);
        check(gate.b, 8'h00);
        // Short serial glitch is dropped, a long low passes
        scl = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(2);
        check({scl_c, sda_c}, 8'h03);
        scl = 1'b0;
        tick(9);
        check({scl_c, sda_c}, 8'h00);
        close_out();
    end
endmodule : tb
